// file: rtl/hap_pkg.sv
package hap_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // ----------------------------------------
  // address layout
  // ----------------------------------------
  // multiproc space: any address whose field from this bit up is zero
  localparam int MPROC_TOP = 22;
  // host drives this line high while awaiting grant to stay out of multiproc space
  localparam int SAFE_ADDR_BIT = 31;
  // ----------------------------------------
  // timing, 40 MHz clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // least wait-ack low time for a read
  localparam int READ_ACK_NS = 70;
  localparam int READ_ACK_CYC = (READ_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least wait-ack low time for a write
  localparam int WRITE_ACK_NS = 15;
  localparam int WRITE_ACK_CYC = (WRITE_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host strobe high time
  localparam int STROBE_HIGH_NS = 6;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CNT_RESET = 4'h0;
endpackage

// file: rtl/hap_if.sv
`timescale 1ns/1ps
interface hap_if;
  // ----------------------------------------
  // link signals, the _n lines are active low strobes
  // ----------------------------------------
  logic device_select_n;
  logic host_bus_request_n;
  logic host_bus_grant_n;
  logic rd_n;
  logic wr_n;
  logic [hap_pkg::ADDR_W-1:0] addr;
  logic [hap_pkg::DATA_W-1:0] host_data;
  logic host_data_oe;
  logic [hap_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic wait_ack_o;
  logic wait_ack_oe;
  logic core_priority_access_n;

  // wire levels: wait-ack pulled up when nobody drives it
  wire wait_ack_n = wait_ack_oe ? wait_ack_o : 1'b1;
  wire [hap_pkg::DATA_W-1:0] data_bus = dev_data_oe ? dev_data :
    (host_data_oe ? host_data : '0);

  modport dev (
    input device_select_n, host_bus_request_n, rd_n, wr_n, addr, host_data,
    input core_priority_access_n, data_bus, wait_ack_n,
    output host_bus_grant_n, dev_data, dev_data_oe, wait_ack_o, wait_ack_oe
  );
  modport host (
    output device_select_n, host_bus_request_n, rd_n, wr_n, addr, host_data,
    output host_data_oe, core_priority_access_n,
    input host_bus_grant_n, data_bus, wait_ack_n
  );
endinterface

// file: rtl/hap_device.sv
`timescale 1ns/1ps
// Function
// - host requests, selects, awaits grant first
// - request and grant stay low throughout
// - first address lies outside multiproc space
// - host holds upper address high until granted
// - bus requests sampled on device clock
// - priority assertion synchronous, release asynchronous
// - wait-ack open-drain or actively driven
// - host holds read until wait-ack released
// - read data valid before wait-ack release
// - host holds write until wait-ack released
// - wait-ack released on clock edge
// - select covers whole write strobe
// - multiproc address match acknowledged regardless; the code holds wait-ack low for the whole strobe on own id match
module hap_device #(
  parameter int READ_CYC = hap_pkg::READ_ACK_CYC,
  parameter int WRITE_CYC = hap_pkg::WRITE_ACK_CYC,
  parameter int MEM_WORDS = 256,
  parameter logic [hap_pkg::ADDR_W-1:hap_pkg::MPROC_TOP] OWN_ID = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // style select: 1 actively driven, 0 open drain
  input wire logic active_drive,
  // status to the core side
  output logic host_owns_bus,
  output logic core_priority,
  // link
  hap_if.dev link
);
  localparam int AW = $clog2(MEM_WORDS);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_GRANT = 4'b0010,
    ST_BUSY = 4'b0100,
    ST_DONE = 4'b1000
  } hap_dev_state_e;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] req_s_r, sel_s_r, rd_s_r, wr_s_r, cpa_s_r;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s_r <= 2'h3;
      sel_s_r <= 2'h3;
      rd_s_r <= 2'h3;
      wr_s_r <= 2'h3;
      cpa_s_r <= 2'h3;
    end
    else
    begin
      req_s_r <= {req_s_r[0], link.host_bus_request_n};
      sel_s_r <= {sel_s_r[0], link.device_select_n};
      rd_s_r <= {rd_s_r[0], link.rd_n};
      wr_s_r <= {wr_s_r[0], link.wr_n};
      cpa_s_r <= {cpa_s_r[0], link.core_priority_access_n};
    end
  end

  wire req = ~req_s_r[1] & ~sel_s_r[1];
  wire rd = ~rd_s_r[1];
  wire wr = ~wr_s_r[1];
  // release is taken straight from the pin, no setup needed
  wire cpa_nxt = ~cpa_s_r[1] & ~link.core_priority_access_n;

  // ----------------------------------------
  // control
  // ----------------------------------------
  hap_dev_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic is_rd_r, is_rd_nxt;
  logic grant_r, grant_n_r, ack_o_r, ack_oe_r, doe_r;
  logic [hap_pkg::DATA_W-1:0] mem [MEM_WORDS];
  logic [hap_pkg::DATA_W-1:0] rdata_r;

  wire mproc = ~|link.addr[hap_pkg::ADDR_W-1:hap_pkg::MPROC_TOP];
  wire own_match = link.addr[hap_pkg::ADDR_W-1:hap_pkg::MPROC_TOP] == OWN_ID;
  wire strobe = (rd | wr) & grant_r;
  wire [AW-1:0] widx = link.addr[AW+1:2];
  wire [3:0] rd_len = 4'(READ_CYC);
  wire [3:0] wr_len = 4'(WRITE_CYC);
  wire grant_nxt = state_nxt != ST_IDLE;
  // ack held low from strobe until count ends, and for the whole strobe on own id match in multiproc space
  wire ack_low_nxt = state_nxt == ST_BUSY || (strobe && mproc && own_match);
  // read data stays driven until the host lifts its strobe
  wire rd_phase_nxt = state_nxt == ST_BUSY || state_nxt == ST_DONE;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    is_rd_nxt = is_rd_r;
    case (state_r)
      ST_IDLE:
        if (req)
          state_nxt = ST_GRANT;
      ST_GRANT:
        if (!req)
          state_nxt = ST_IDLE;
        else if (strobe)
        begin
          state_nxt = ST_BUSY;
          is_rd_nxt = rd;
          cnt_nxt = rd ? rd_len : wr_len;
        end
      ST_BUSY:
        if (cnt_r > 4'h1)
          cnt_nxt = cnt_r - 4'h1;
        else
          state_nxt = ST_DONE;
      ST_DONE:
        if (!rd && !wr)
          state_nxt = req ? ST_GRANT : ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= hap_pkg::CNT_RESET;
      is_rd_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      is_rd_r <= is_rd_nxt;
    end
  end

  // memory; multiproc addresses are never stored, and acked except on own id match, where ack stays low through the strobe
  wire wr_commit = state_r == ST_BUSY && cnt_r == 4'h1 && !is_rd_r && !mproc;
  always_ff @(posedge clk)
  begin
    if (wr_commit)
      mem[widx] <= link.data_bus;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      grant_r <= 1'b0;
      grant_n_r <= 1'b1;
      host_owns_bus <= 1'b0;
      core_priority <= 1'b0;
    end
    else
    begin
      grant_r <= grant_nxt;
      grant_n_r <= ~grant_nxt;
      host_owns_bus <= grant_nxt;
      core_priority <= cpa_nxt;
    end
  end

  // ----------------------------------------
  // wait-ack drive
  // ----------------------------------------
  // registered so the release lands just after a clock edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_o_r <= 1'b0;
      ack_oe_r <= 1'b0;
    end
    else
    begin
      ack_o_r <= ~ack_low_nxt & active_drive;
      // active drive holds high while granted; open drain only pulls low
      ack_oe_r <= ack_low_nxt | (active_drive & grant_nxt);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_r <= '0;
      doe_r <= 1'b0;
    end
    else
    begin
      if (state_r == ST_GRANT && strobe)
        rdata_r <= mem[widx];
      // enabled with the ack, so data is valid well before its release
      doe_r <= is_rd_nxt & rd & rd_phase_nxt;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign link.host_bus_grant_n = grant_n_r;
  assign link.wait_ack_o = ack_o_r;
  assign link.wait_ack_oe = ack_oe_r;
  assign link.dev_data = rdata_r;
  assign link.dev_data_oe = doe_r;
endmodule

// file: rtl/hap_host.sv
`timescale 1ns/1ps
module hap_host (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // user request
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [hap_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [hap_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [hap_pkg::DATA_W-1:0] rsp_rdata,
  // priority request toward the device core
  input wire logic prio_req,
  // link
  hap_if.host link
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_REQ = 5'b00010,
    H_STROBE = 5'b00100,
    H_WAIT = 5'b01000,
    H_GAP = 5'b10000
  } hap_host_state_e;

  logic [1:0] gnt_s_r, ack_s_r;
  hap_host_state_e st_r;
  logic req_r, rd_r, wr_r, doe_r, seen_low_r, prio_r;
  logic [hap_pkg::ADDR_W-1:0] addr_r;
  logic [hap_pkg::DATA_W-1:0] wdata_r;
  wire granted = ~gnt_s_r[1];
  wire ack_low = ~ack_s_r[1];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gnt_s_r <= 2'h3;
      ack_s_r <= 2'h3;
      st_r <= H_IDLE;
      req_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      doe_r <= 1'b0;
      seen_low_r <= 1'b0;
      prio_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      gnt_s_r <= {gnt_s_r[0], link.host_bus_grant_n};
      ack_s_r <= {ack_s_r[0], link.wait_ack_n};
      prio_r <= prio_req;
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      case (st_r)
        H_IDLE:
          if (cmd_valid)
          begin
            req_r <= 1'b1;
            // upper line high keeps the first address out of multiproc space
            addr_r <= cmd_addr | (32'h1 << hap_pkg::SAFE_ADDR_BIT);
            wdata_r <= cmd_wdata;
            st_r <= H_REQ;
          end
        H_REQ:
          if (granted)
          begin
            addr_r <= cmd_addr;
            rd_r <= ~cmd_write;
            wr_r <= cmd_write;
            doe_r <= cmd_write;
            seen_low_r <= 1'b0;
            st_r <= H_STROBE;
          end
        H_STROBE:
          if (ack_low)
          begin
            seen_low_r <= 1'b1;
            st_r <= H_WAIT;
          end
        H_WAIT:
          if (!ack_low && seen_low_r)
          begin
            rsp_rdata <= link.data_bus;
            rsp_valid <= rd_r;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            st_r <= H_GAP;
          end
        H_GAP:
        begin
          doe_r <= 1'b0;
          req_r <= 1'b0;
          // a grant still in the synchroniser would pass the next strobe early
          if (!granted && !req_r)
          begin
            cmd_ready <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default:
          st_r <= H_IDLE;
      endcase
    end
  end

  assign link.host_bus_request_n = ~req_r;
  assign link.device_select_n = ~req_r;
  assign link.rd_n = ~rd_r;
  assign link.wr_n = ~wr_r;
  assign link.addr = addr_r;
  assign link.host_data = wdata_r;
  assign link.host_data_oe = doe_r;
  assign link.core_priority_access_n = ~prio_r;
endmodule

// file: bench/hap_monitor.sv
`timescale 1ns/1ps
module hap_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link signals
  input logic device_select_n,
  input logic host_bus_request_n,
  input logic host_bus_grant_n,
  input logic rd_n,
  input logic wr_n,
  input logic [31:0] addr,
  input logic dev_data_oe,
  input logic wait_ack_n
);
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_grant_on_request: assert property ($fell(host_bus_grant_n) |-> !host_bus_request_n)
    else $error("grant without request");
  a_grant_kept: assert property
    (!host_bus_grant_n && !host_bus_request_n ##1 !host_bus_request_n |-> !host_bus_grant_n)
    else $error("grant dropped while requested");
  a_no_ack_ungranted: assert property (host_bus_grant_n |-> wait_ack_n)
    else $error("wait-ack without grant");
  a_strobe_qualified: assert property ((!rd_n || !wr_n) |-> !host_bus_grant_n)
    else $error("strobe before grant");
  a_safe_address: assert property ((!rd_n || !wr_n) |-> addr[31])
    else $error("strobe with multiproc address");
  a_select_covers_write: assert property (!wr_n |-> !device_select_n)
    else $error("write strobe without select");
  a_read_ack_width: assert property ($fell(wait_ack_n) && !rd_n |-> !wait_ack_n [*3])
    else $error("read wait-ack too short");
  a_ack_release: assert property ($fell(wait_ack_n) |-> ##[1:16] $rose(wait_ack_n))
    else $error("wait-ack never released");
  a_read_data_first: assert property ($rose(wait_ack_n) && !rd_n |-> $past(dev_data_oe))
    else $error("read data late");
  a_read_held: assert property ($rose(rd_n) |-> $past(wait_ack_n))
    else $error("read strobe raised early");
  a_write_held: assert property ($rose(wr_n) |-> $past(wait_ack_n))
    else $error("write strobe raised early");
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk;
  logic arst_n;
  logic active_drive;
  logic cmd_valid;
  logic cmd_write;
  logic [31:0] cmd_addr;
  logic [31:0] cmd_wdata;
  logic cmd_ready;
  logic rsp_valid;
  logic [31:0] rsp_rdata;
  logic host_owns_bus;
  logic core_priority;
  logic prio_req;
  logic [31:0] got;
  logic ack_seen;
  int n_mismatch;
  int num_checks;
  hap_if link();
  hap_device u_hap_device (.clk(clk), .arst_n(arst_n), .active_drive(active_drive),
    .host_owns_bus(host_owns_bus), .core_priority(core_priority), .link(link));
  hap_host u_hap_host (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .prio_req(prio_req), .link(link));
  hap_monitor u_hap_monitor (.clk(clk), .arst_n(arst_n), .device_select_n(link.device_select_n),
    .host_bus_request_n(link.host_bus_request_n), .host_bus_grant_n(link.host_bus_grant_n),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .addr(link.addr), .dev_data_oe(link.dev_data_oe),
    .wait_ack_n(link.wait_ack_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one whole host access; watches the wire every cycle
  task access(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    int ack_cnt;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    ack_seen = 1'b0;
    ack_cnt = 0;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
        got = rsp_rdata;
      if (link.wait_ack_n === 1'b0)
      begin
        ack_seen = 1'b1;
        ack_cnt++;
      end
      if (!active_drive && link.wait_ack_oe === 1'b1)
        check("open drain level", link.wait_ack_o, 1'b0);
      if (active_drive && link.host_bus_grant_n === 1'b0)
        check("active drive", link.wait_ack_oe, 1'b1);
      if (link.rd_n === 1'b0 || link.wr_n === 1'b0)
        check("strobe qualifiers", {link.addr[31], link.device_select_n,
          link.host_bus_grant_n}, 3'b100);
    end
    cmd_valid = 1'b0;
    check("ready", cmd_ready, 1'b1);
    check("ack seen", ack_seen, 1'b1);
    check("ack cycles", ack_cnt, w ? hap_pkg::WRITE_ACK_CYC : hap_pkg::READ_ACK_CYC);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_burst;
    logic [31:0] adr [4];
    int k;
    adr = '{32'h8000_0000, 32'h8000_0004, 32'h8000_03f8, 32'h8000_03fc};
    for (k = 0; k < 4; k++)
    begin
      active_drive = k[0];
      access(1'b1, adr[k], 32'ha5c3_0000 ^ adr[k]);
    end
    for (k = 0; k < 4; k++)
    begin
      active_drive = ~k[0];
      got = 32'h0;
      access(1'b0, adr[k], 32'h0);
      check("read data", got, 32'ha5c3_0000 ^ adr[k]);
    end
    check("priority idle", core_priority, 1'b0);
  endtask
  // reset lands while the host holds the bus
  task t_mid_reset;
    int i;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_addr = 32'h8000_0010;
    for (i = 0; i < 50 && link.host_bus_grant_n !== 1'b0; i++)
      @(negedge clk);
    check("owns bus", host_owns_bus, 1'b1);
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    @(negedge clk);
    check("reset state", {link.host_bus_grant_n, link.wait_ack_n, link.dev_data_oe,
      host_owns_bus}, 4'hc);
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    access(1'b1, 32'h8000_0020, 32'h1234_5678);
    access(1'b0, 32'h8000_0020, 32'h0);
    check("read after reset", got, 32'h1234_5678);
  endtask
  // priority assertion goes through the synchroniser, release does not
  task t_priority;
    @(negedge clk);
    prio_req = 1'b1;
    repeat (3) @(negedge clk);
    check("priority early", core_priority, 1'b0);
    @(negedge clk);
    check("priority set", core_priority, 1'b1);
    prio_req = 1'b0;
    @(negedge clk);
    check("priority held", core_priority, 1'b1);
    @(negedge clk);
    check("priority released", core_priority, 1'b0);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    arst_n = 1'b0;
    active_drive = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h0;
    cmd_wdata = 32'h0;
    got = 32'h0;
    n_mismatch = 0;
    num_checks = 0;
    prio_req = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_burst;
    t_mid_reset;
    t_priority;
    finish_test;
  end
endmodule
